// file: src/adccw_decode.v
// adccw_decode.v: first control word decoder and conversion control
// assumes a synchronous host write strobe and an async conversion pin
//
// Overview of operation
// - bit 0 picks internal or external reference
// - mode 0 runs continuous on conversion clock
// - continuous: one FIFO write per falling edge
// - mode 1 makes the pin active-low start
// - start falling edge holds inputs, starts sequence
// - data available active when trigger is met
// - bit 2 powers converter down or up
// - port and FIFO reads still work powered down
// - bits 3,4 pick channel, reset zero
// - bits 5,6 count differentials, reset 1,0
// - bit 7 enables autoscan, reset zero
// - bits 8,9 select test, reset zero
// - test mode keeps data available disabled
// - both upper address bits zero select word
// - test code picks normal, plus, mid, minus
// - trigger met when writes reach trigger level
// - bit 5 picks differential; reserved combos flagged
`timescale 1ns/10ps
`include "adccw_regs.vh"
module adccw_decode
#(
  parameter CONV_CYCLES = `ADCCW_CONV_CYCLES,
  parameter CH_COUNT_W = 2
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire reg_addr_bit0_i,
  input wire reg_addr_bit1_i,
  input wire [9:0] data_i,
  input wire [3:0] trig_level_i,
  input wire fifo_read_i,
  input wire conversion_clock_in_i,
  output reg [9:0] conversion_setup_word_o,
  output reg ext_ref_sel_o,
  output reg power_down_o,
  output reg [1:0] input_select_o,
  output reg [1:0] diff_count_o,
  output reg scan_en_o,
  output reg [1:0] test_sel_o,
  output reg differential_o,
  output reg reserved_cfg_o,
  output reg hold_o,
  output reg busy_o,
  output reg [CH_COUNT_W-1:0] channel_o,
  output reg fifo_write_o,
  output reg data_available_out_o
);
  ////////////////////////////////////////////////////////////////////////
  // setup word storage
  // current setup word
  reg [9:0] setup;
  // the write addresses this word
  wire sel_setup;
  assign sel_setup = wr_i &
    ({reg_addr_bit1_i, reg_addr_bit0_i} == `ADCCW_ADDR_SETUP);
  // whole word loads at once from the write cycle
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      setup <= `ADCCW_SETUP_RESET;
    else if (sel_setup)
      setup <= data_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // field decode
  // mode and test fields
  wire single_mode;
  wire test_active;
  wire [4:0] cfg;
  assign single_mode = setup[`ADCCW_BIT_MODE];
  assign test_active = setup[`ADCCW_BIT_TEST_HI:`ADCCW_BIT_TEST_LO] !=
    `ADCCW_TEST_NORMAL;
  assign cfg = setup[`ADCCW_BIT_SCAN:`ADCCW_BIT_CH_LO];
  // reserved combination detector; cfg is {scan,diff_count_hi,diff_count_lo,ch1,ch0}
  reg reserved_cfg;
  // number of channels in the scan sequence minus one
  reg [1:0] scan_last;
  always @*
  begin
    reserved_cfg = 1'b0;
    scan_last = 2'h0;
    case (cfg)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: scan_last = 2'h0;
      5'h11: scan_last = 2'h1;
      5'h12: scan_last = 2'h2;
      5'h13: scan_last = 2'h3;
      5'h15: scan_last = 2'h1;
      5'h16: scan_last = 2'h2;
      5'h19: scan_last = 2'h1;
      default: reserved_cfg = 1'b1;
    endcase
  end
  // decoded fields registered for the analog side
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conversion_setup_word_o <= `ADCCW_SETUP_RESET;
      ext_ref_sel_o <= 1'b0;
      power_down_o <= 1'b0;
      input_select_o <= 2'h0;
      diff_count_o <= 2'h1;
      scan_en_o <= 1'b0;
      test_sel_o <= `ADCCW_TEST_NORMAL;
      differential_o <= 1'b1;
      reserved_cfg_o <= 1'b0;
    end
    else
    begin
      conversion_setup_word_o <= setup;
      ext_ref_sel_o <= setup[`ADCCW_BIT_REF];
      power_down_o <= setup[`ADCCW_BIT_PD];
      input_select_o <= setup[`ADCCW_BIT_CH_HI:`ADCCW_BIT_CH_LO];
      diff_count_o <= setup[`ADCCW_BIT_DIFF_HI:`ADCCW_BIT_DIFF_LO];
      scan_en_o <= setup[`ADCCW_BIT_SCAN];
      test_sel_o <= setup[`ADCCW_BIT_TEST_HI:`ADCCW_BIT_TEST_LO];
      differential_o <= setup[`ADCCW_BIT_DIFF_LO];
      reserved_cfg_o <= reserved_cfg;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // conversion pin
  // only the falling edge is used; the filtered level is left open
  wire pin_fall;
  adccw_edge_sync adccw_edge_sync_i
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(conversion_clock_in_i),
    .level_o(),
    .fall_o(pin_fall)
  );
  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  localparam CNT_W = 8;
  // sequencer state
  reg state;
  // cycles left for the current channel
  reg [CNT_W-1:0] cnt;
  // channel within the scan sequence
  reg [1:0] seq;
  // converter may run
  wire run;
  assign run = ~power_down_o;
  // single mode walk through held channels, continuous writes per edge
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      seq <= 2'h0;
      hold_o <= 1'b0;
      busy_o <= 1'b0;
      fifo_write_o <= 1'b0;
      channel_o <= {CH_COUNT_W{1'b0}};
    end
    else
    begin
      fifo_write_o <= 1'b0;
      // bus and FIFO stay alive, only conversion stops
      if (!run)
      begin
        state <= ST_IDLE;
        hold_o <= 1'b0;
        busy_o <= 1'b0;
        seq <= 2'h0;
      end
      else if (!single_mode)
      begin
        // one write per falling conversion clock edge
        state <= ST_IDLE;
        hold_o <= 1'b0;
        busy_o <= 1'b0;
        if (pin_fall)
        begin
          fifo_write_o <= 1'b1;
          channel_o <= seq[CH_COUNT_W-1:0];
          seq <= (seq == scan_last) ? 2'h0 : seq + 2'h1;
        end
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            seq <= 2'h0;
            if (pin_fall)
            begin
              hold_o <= 1'b1;
              busy_o <= 1'b1;
              cnt <= CONV_CYCLES[CNT_W-1:0];
              state <= ST_CONV;
            end
          end
          ST_CONV:
          begin
            if (cnt > 8'h01)
              cnt <= cnt - 8'h01;
            else
            begin
              fifo_write_o <= 1'b1;
              channel_o <= seq[CH_COUNT_W-1:0];
              cnt <= CONV_CYCLES[CNT_W-1:0];
              if (seq == scan_last)
              begin
                hold_o <= 1'b0;
                busy_o <= 1'b0;
                state <= ST_IDLE;
              end
              else
                seq <= seq + 2'h1;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // trigger counting and data available
  // values written since last trigger
  reg [3:0] wr_count;
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_count <= 4'h0;
      data_available_out_o <= 1'b0;
    end
    else
    begin
      data_available_out_o <= 1'b0;
      if (fifo_write_o)
      begin
        if (wr_count + 4'h1 >= trig_level_i)
        begin
          wr_count <= 4'h0;
          data_available_out_o <= ~test_active;
        end
        else
          wr_count <= wr_count + 4'h1;
      end
    end
  end
endmodule

// file: src/adccw_regs.vh
// adccw_regs.vh: constants for the conversion setup word decoder
// assumes inclusion by the decoder only
`ifndef ADCCW_REGS_VH
`define ADCCW_REGS_VH
// register select code on the two upper address bits
`define ADCCW_ADDR_SETUP 2'h0
// field positions inside the ten-bit setup word
`define ADCCW_BIT_REF 0
`define ADCCW_BIT_MODE 1
`define ADCCW_BIT_PD 2
`define ADCCW_BIT_CH_LO 3
`define ADCCW_BIT_CH_HI 4
`define ADCCW_BIT_DIFF_LO 5
`define ADCCW_BIT_DIFF_HI 6
`define ADCCW_BIT_SCAN 7
`define ADCCW_BIT_TEST_LO 8
`define ADCCW_BIT_TEST_HI 9
// reset value: only diff_count_lo is set
`define ADCCW_SETUP_RESET 10'h020
// test selection codes
`define ADCCW_TEST_NORMAL 2'h0
`define ADCCW_TEST_POS 2'h1
`define ADCCW_TEST_MID 2'h2
`define ADCCW_TEST_NEG 2'h3
// defaults for the pipeline timing and trigger counting
`define ADCCW_CONV_CYCLES 4
`define ADCCW_TRIG_RESET 4'h1
`endif

// file: src/adccw_edge_sync.v
// adccw_edge_sync.v: three-stage synchroniser with falling edge detect
// assumes the input is asynchronous to clk_i
`timescale 1ns/10ps
module adccw_edge_sync
(
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output wire level_o,
  output wire fall_o
);
  // synchroniser chain; stage 0 feeds stage 1 only
  reg [2:0] sync;
  // filtered pin level, moves only when stages 1 and 2 agree
  reg level;
  // shift the pin in; reset idles high as the pin rests high
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sync <= 3'h7;
    else
      sync <= {sync[1:0], pin_i};
  end
  // accept a new level only once the last two stages agree
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      // pin rests high, so no false edge after reset
      level <= 1'b1;
    else if (sync[2] == sync[1])
      level <= sync[2];
  end
  // falling edge: stable high level meets two agreeing low stages
  assign level_o = level;
  assign fall_o = level & ~sync[2] & ~sync[1];
endmodule

// file: tb/adccw_decode_monitor.sv
// adccw_decode_monitor.sv: port assertions for the setup word decoder
// assumes it is bound onto adccw_decode, one clock domain
`timescale 1ns/10ps
module adccw_decode_monitor
(
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire reg_addr_bit0_i,
  input wire reg_addr_bit1_i,
  input wire [9:0] data_i,
  input wire [9:0] conversion_setup_word_o,
  input wire ext_ref_sel_o,
  input wire power_down_o,
  input wire [1:0] test_sel_o,
  input wire hold_o,
  input wire busy_o,
  input wire fifo_write_o,
  input wire data_available_out_o
);
  // write aimed at the setup word
  wire sel = wr_i && !reg_addr_bit0_i && !reg_addr_bit1_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  word_update_a:
    assert property (sel ##1 !sel |=>
      conversion_setup_word_o == $past(data_i, 2))
    else $error("setup word not loaded");
  addr_refuse_a:
    assert property (!sel ##1 (wr_i && (reg_addr_bit0_i || reg_addr_bit1_i))
      |=> ##1 $stable(conversion_setup_word_o))
    else $error("setup word changed by other address");
  ref_field_a:
    assert property (sel ##1 !sel |=> ext_ref_sel_o == $past(data_i[0], 2))
    else $error("reference select wrong");
  pd_field_a:
    assert property (sel ##1 !sel |=> power_down_o == $past(data_i[2], 2))
    else $error("power down wrong");
  test_field_a:
    assert property (sel ##1 !sel |=> test_sel_o == $past(data_i[9:8], 2))
    else $error("test select wrong");
  test_quiet_a:
    assert property (test_sel_o != 2'h0 |-> !data_available_out_o)
    else $error("data available during test");
  hold_busy_a:
    assert property ($fell(hold_o) && !power_down_o &&
      conversion_setup_word_o[1] |-> fifo_write_o && !busy_o)
    else $error("hold ended without final write");
  avail_cause_a:
    assert property (data_available_out_o |-> $past(fifo_write_o))
    else $error("data available without write");
  pd_idle_a:
    assert property (power_down_o && $past(power_down_o)
      |-> !fifo_write_o && !hold_o)
    else $error("conversion while powered down");
endmodule
bind adccw_decode adccw_decode_monitor adccw_decode_monitor_i (.clk_i,
  .rst_i, .wr_i, .reg_addr_bit0_i, .reg_addr_bit1_i, .data_i,
  .conversion_setup_word_o, .ext_ref_sel_o, .power_down_o, .test_sel_o,
  .hold_o, .busy_o, .fifo_write_o, .data_available_out_o);

// file: tb/adccw_host_model.sv
// adccw_host_model.sv: host making port writes and conversion pin pulses
// assumes a free running clk_i from the bench
`timescale 1ns/10ps
module adccw_host_model
(
  input wire clk_i,
  output reg wr_o,
  output reg addr0_o,
  output reg addr1_o,
  output reg [9:0] data_o,
  output reg pin_o
);
  // idle bus, pin high
  initial
  begin
    wr_o = 1'b0;
    addr0_o = 1'b0;
    addr1_o = 1'b0;
    data_o = 10'h2AA;
    pin_o = 1'b1;
  end
  task write_word(input [1:0] a, input [9:0] d);
  begin
    @(posedge clk_i);
    wr_o <= 1'b1;
    {addr1_o, addr0_o} <= a;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~d;
  end
  endtask
  task pin_pulses(input integer n);
    integer k;
  begin
    for (k = 0; k < n; k = k + 1)
    begin
      @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
  end
  endtask
endmodule

// file: tb/adccw_decode_tb.sv
// adccw_decode_tb.sv: self-checking bench for the setup word decoder
// assumes the host model and monitor are compiled first
`timescale 1ns/10ps
module adccw_decode_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] trig_level_i = 4'h4;
  reg fifo_read_i = 1'b0;
  wire wr_i, reg_addr_bit0_i, reg_addr_bit1_i, conversion_clock_in_i;
  wire [9:0] data_i, conversion_setup_word_o;
  wire [1:0] input_select_o, diff_count_o, test_sel_o, channel_o;
  // channel index of each value written, newest in the low bits
  reg [9:0] ch_log = 10'h000;
  wire ext_ref_sel_o, power_down_o, scan_en_o, differential_o;
  wire reserved_cfg_o, hold_o, busy_o, fifo_write_o, data_available_out_o;
  integer error_cnt = 0, checks = 0, fw = 0, dav = 0;
  always #20 clk_i = ~clk_i;
  // count output pulses
  always @(posedge clk_i)
  begin
    fw = fw + fifo_write_o;
    dav = dav + data_available_out_o;
    if (fifo_write_o)
      ch_log = {ch_log[7:0], channel_o};
  end
  adccw_host_model adccw_host_model_i (.clk_i, .wr_o(wr_i),
    .addr0_o(reg_addr_bit0_i), .addr1_o(reg_addr_bit1_i), .data_o(data_i),
    .pin_o(conversion_clock_in_i));
  adccw_decode adccw_decode_i (.clk_i, .rst_i, .wr_i, .reg_addr_bit0_i,
    .reg_addr_bit1_i, .data_i, .trig_level_i, .fifo_read_i,
    .conversion_clock_in_i, .conversion_setup_word_o, .ext_ref_sel_o,
    .power_down_o, .input_select_o, .diff_count_o, .scan_en_o, .test_sel_o,
    .differential_o, .reserved_cfg_o, .hold_o, .busy_o, .channel_o,
    .fifo_write_o, .data_available_out_o);
  task chk(input [63:0] what, input [9:0] exp, input [9:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s exp %h got %h", what, exp, got);
    end
  end
  endtask
  // write, let decoded outputs land, compare all fields but the mode bit
  task put(input [9:0] w);
  begin
    adccw_host_model_i.write_word(2'h0, w);
    repeat (2) @(negedge clk_i);
    chk("word", w, conversion_setup_word_o);
    chk("fields", w, {test_sel_o, scan_en_o, diff_count_o, input_select_o,
      power_down_o, w[1], ext_ref_sel_o});
    fw = 0;
    dav = 0;
    ch_log = 10'h000;
  end
  endtask
  // pulse the pin, then compare pulse counts
  task run(input integer n, input [9:0] ew, input [9:0] ed);
  begin
    adccw_host_model_i.pin_pulses(n);
    repeat (40) @(negedge clk_i);
    chk("writes", ew, fw[9:0]);
    chk("avail", ed, dav[9:0]);
  end
  endtask
  task final_report;
  begin
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset", 10'h020, conversion_setup_word_o);
    // field table, reserved flags 0,1,0,1, all four test codes
    put(10'h000);
    chk("cfg", 10'h000, {differential_o, reserved_cfg_o});
    put(10'h130);
    chk("cfg", 10'h003, {differential_o, reserved_cfg_o});
    put(10'h299);
    chk("cfg", 10'h000, {differential_o, reserved_cfg_o});
    put(10'h3C5);
    chk("cfg", 10'h001, {differential_o, reserved_cfg_o});
    adccw_host_model_i.write_word(2'h1, 10'h155);
    adccw_host_model_i.write_word(2'h3, 10'h155);
    repeat (2) @(negedge clk_i);
    chk("refused", 10'h3C5, conversion_setup_word_o);
    put(10'h000);
    run(8, 10'h008, 10'h002);
    put(10'h09A);
    run(1, 10'h004, 10'h001);
    chk("chan", 10'h01B, ch_log);
    put(10'h100);
    run(4, 10'h004, 10'h000);
    put(10'h000);
    run(4, 10'h004, 10'h001);
    // trigger level one: every write raises data available
    @(posedge clk_i);
    trig_level_i <= 4'h1;
    put(10'h000);
    run(2, 10'h002, 10'h002);
    put(10'h004);
    run(4, 10'h000, 10'h000);
    put(10'h005);
    final_report;
  end
endmodule
